// ===== logic/mfmsep_pkg.sv
`default_nettype none
package mfmsep_pkg;

	// System clock
	localparam int CLK_NS = 20;

	// Register port geometry
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_STAT = 2'h1;

	// Control word layout and reset value
	localparam int CTRL_GATE_BIT  = 0;
	localparam int CTRL_CLASS_BIT = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_MASK  = 8'h03;

	// Status word layout
	localparam int STAT_RUN_BIT   = 0;
	localparam int STAT_ALIGN_BIT = 1;
	localparam int STAT_UP_BIT    = 2;
	localparam int STAT_DOWN_BIT  = 3;
	localparam int STAT_CNT_LSB   = 4;

	// Crystal runs at this multiple of the recovered clock
	localparam int OSC_MULT = 4;
	localparam logic [1:0] DIV_RESET = 2'h0;

	// Gap timeout per drive class, 1.25 recovered periods, rounded down
	localparam int GAP_NS_A = 250;
	localparam int GAP_NS_B = 287;
	localparam logic [4:0] GAP_CYC_A = 5'(GAP_NS_A / CLK_NS);
	localparam logic [4:0] GAP_CYC_B = 5'(GAP_NS_B / CLK_NS);

	// Run detector terminal count
	localparam logic [4:0] RUN_TERMINAL = 5'h10;

	// Phase detector window: delay tap minus propagation, rounded down
	localparam int DLY_TAP_NS  = 60;
	localparam int DLY_PROP_NS = 10;
	localparam logic [2:0] WIN_CYC = 3'((DLY_TAP_NS - DLY_PROP_NS) / CLK_NS);

	// Data bits that end the phase alignment pulse
	localparam logic [1:0] ALIGN_BITS = 2'h2;

	// Phase alignment sequencer
	typedef enum logic [1:0] {
		PA_IDLE     = 2'b00,
		PA_WAIT_VCO = 2'b01,
		PA_HOLD     = 2'b10,
		PA_DONE     = 2'b11
	} mfmsep_pa_t;

	// Rising edge seen between two synchronised samples
	function automatic logic mfmsep_rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

endpackage
`default_nettype wire

// ===== logic/mfmsep_run_det.sv
`timescale 1ns/10ps
`default_nettype none
module mfmsep_run_det (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Control
	input  wire logic       bit_rise,
	input  wire logic       enable,
	input  wire logic       class_sel,
	// Status
	output logic            run_detected_n,
	output logic [4:0]      run_count
);
	import mfmsep_pkg::*;

	logic [4:0] gap_r;
	logic [4:0] gap_nxt;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic       run_n_r;
	logic       run_n_nxt;
	logic [4:0] gap_load;
	logic       expire;
	logic [4:0] cnt_inc;

	// Timeout follows the selected drive class
	assign gap_load = class_sel ? GAP_CYC_B : GAP_CYC_A;
	assign expire   = (gap_r == 5'h01) && !bit_rise;
	assign cnt_inc  = (cnt_r == RUN_TERMINAL) ? cnt_r : 5'(cnt_r + 5'h01);

	// Each bit retriggers the timer; a late bit starts a fresh run of one
	assign gap_nxt = !enable ? 5'h00 :
		bit_rise ? gap_load :
		(gap_r != 5'h00) ? 5'(gap_r - 5'h01) : 5'h00;
	assign cnt_nxt = !enable ? 5'h00 :
		bit_rise ? ((gap_r != 5'h00) ? cnt_inc : 5'h01) :
		expire ? 5'h00 : cnt_r;
	// Latch is sticky until the gate drops
	assign run_n_nxt = !enable ? 1'b1 :
		(cnt_r == RUN_TERMINAL) ? 1'b0 : run_n_r;

	// State registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gap_r   <= 5'h00;
			cnt_r   <= 5'h00;
			run_n_r <= 1'b1;
		end else begin
			gap_r   <= gap_nxt;
			cnt_r   <= cnt_nxt;
			run_n_r <= run_n_nxt;
		end
	end

	assign run_detected_n = run_n_r;
	assign run_count      = cnt_r;

	property p_expire_clears;
		@(posedge clk_sys) disable iff (rst)
		(enable && gap_r == 5'h01 && !bit_rise) |=> (cnt_r == 5'h00);
	endproperty
	a_expire_clears: assert property (p_expire_clears) else $error("run count not cleared on gap timeout");

	property p_terminal_sets;
		@(posedge clk_sys) disable iff (rst)
		(enable && cnt_r == RUN_TERMINAL) |=> !run_detected_n;
	endproperty
	a_terminal_sets: assert property (p_terminal_sets) else $error("run latch not set at terminal count");

	property p_no_early_run;
		@(posedge clk_sys) disable iff (rst)
		($fell(run_detected_n)) |-> ($past(cnt_r) == RUN_TERMINAL);
	endproperty
	a_no_early_run: assert property (p_no_early_run) else $error("run latch set before sixteen bits");

endmodule
`default_nettype wire

// ===== logic/mfmsep_top.sv
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Timing comes from a crystal at four times the recovered clock.
// - Divide the crystal into a 2x reference and a 1x write clock.
// - Crystal is 20.000 MHz for class A drives, 17.360 MHz for class B.
// - With no read in progress the loop sees the 2x reference.
// - After read gate, switch in data only after 16 evenly spaced bits.
// - Gap timeout is 1.25 recovered periods: 250 ns or 287 ns.
// - Each bit retriggers the timer and counts; a timeout clears the count.
// - Terminal count sets the run latch low, selecting drive data.
// - Run latch state is readable by the processor on a status port.
// - Recovered clock is the VCO divided by two.
// - After switching, align pulse holds the VCO high until the second bit.
// - Detector window opens on a data edge, closes 50 ns later.
// - Delayed bit sets pump up, VCO edge pump down; both set resets both.
// - Data leading gives net pump up; VCO leading gives net pump down.
// - Balanced loop asserts and releases both pumps together.
module mfmsep_top (
	// Clock and reset
	input  wire logic                         clk_sys,
	input  wire logic                         rst,
	// Register port
	input  wire logic [mfmsep_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [mfmsep_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [mfmsep_pkg::DATA_W-1:0] reg_rdata,
	// Crystal, drive data and VCO pins
	input  wire logic                         osc_4x_in,
	input  wire logic                         mfm_data_in,
	input  wire logic                         vco_in,
	// Clock outputs
	output logic                              reference_clock_2x,
	output logic                              write_clock_1x,
	output logic                              recovered_clock,
	// Loop outputs
	output logic                              loop_input,
	output logic                              phase_align_pulse_n,
	output logic                              pump_up,
	output logic                              pump_down,
	output logic                              run_detected_n
);
	import mfmsep_pkg::*;

	// Synchronisers, stage 0 feeds stage 1 only
	logic [2:0] osc_sync_r;
	logic [2:0] data_sync_r;
	logic [2:0] vco_sync_r;
	logic       osc_rise;
	logic       data_rise;
	logic       vco_rise;
	logic       ref_rise;
	logic       loop_rise;

	// Dividers
	logic [1:0] div_r;
	logic [1:0] div_nxt;
	logic       rclk_r;

	// Register file
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] stat_word;
	logic       read_gate;
	logic       class_sel;

	// Run detector
	logic       run_n;
	logic [4:0] run_count;

	// Loop input selection
	logic       loop_r;
	logic       loop_nxt;

	// Phase alignment
	mfmsep_pa_t pa_r;
	mfmsep_pa_t pa_nxt;
	logic [1:0] pa_bits_r;
	logic [1:0] pa_bits_nxt;
	logic       align_n_r;

	// Phase detector
	logic       armed_r;
	logic       armed_nxt;
	logic [2:0] win_r;
	logic [2:0] win_nxt;
	logic       up_r;
	logic       up_nxt;
	logic       down_r;
	logic       down_nxt;
	logic       both_set;

	// Pin synchronisers; the crystal is sampled like any other pin
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			osc_sync_r  <= 3'h0;
			data_sync_r <= 3'h0;
			vco_sync_r  <= 3'h0;
		end else begin
			osc_sync_r  <= {osc_sync_r[1:0], osc_4x_in};
			data_sync_r <= {data_sync_r[1:0], mfm_data_in};
			vco_sync_r  <= {vco_sync_r[1:0], vco_in};
		end
	end

	// Edge detection looks only at synchronised stages
	assign osc_rise  = mfmsep_rise(osc_sync_r[1], osc_sync_r[2]);
	assign data_rise = mfmsep_rise(data_sync_r[1], data_sync_r[2]);
	assign vco_rise  = mfmsep_rise(vco_sync_r[1], vco_sync_r[2]);
	// Reference is about to rise when bit 0 is low on a crystal edge
	assign ref_rise  = osc_rise && !div_r[0];
	assign loop_rise = run_n ? ref_rise : data_rise;

	// Crystal divider: bit 0 is the 2x reference, bit 1 the 1x write clock
	assign div_nxt = osc_rise ? 2'(div_r + 2'h1) : div_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_r  <= DIV_RESET;
			rclk_r <= 1'b0;
		end else begin
			div_r  <= div_nxt;
			rclk_r <= vco_rise ? !rclk_r : rclk_r;
		end
	end

	// Control port; only the gate and class bits are kept
	assign read_gate = ctrl_r[CTRL_GATE_BIT];
	// Class picks the timeout matching the fitted crystal
	assign class_sel = ctrl_r[CTRL_CLASS_BIT];
	assign ctrl_nxt  = (reg_wr && reg_addr == REG_CTRL) ? (reg_wdata & CTRL_MASK) : ctrl_r;

	// Status word carries the live run latch
	assign stat_word = {run_count[3:0], down_r, up_r, align_n_r, run_n};

	// Read data stand for one cycle only, zero otherwise or when unmapped
	assign rdata_nxt = !reg_rd ? 8'h00 :
		(reg_addr == REG_CTRL) ? ctrl_r :
		(reg_addr == REG_STAT) ? stat_word : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_r  <= CTRL_RESET;
			rdata_r <= 8'h00;
		end else begin
			ctrl_r  <= ctrl_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Run detector watches raw drive data only while the gate is up
	mfmsep_run_det u_run_det (
		.clk_sys        (clk_sys),
		.rst            (rst),
		.bit_rise       (data_rise),
		.enable         (read_gate),
		.class_sel      (class_sel),
		.run_detected_n (run_n),
		.run_count      (run_count)
	);

	// Loop input: reference until the run latch falls, then drive data
	assign loop_nxt = run_n ? div_r[0] : data_sync_r[1];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			loop_r <= 1'b0;
		end else begin
			loop_r <= loop_nxt;
		end
	end

	// Alignment sequencer; counting starts at the VCO edge so the pulse
	// never cuts a VCO half cycle short
	always_comb begin
		pa_nxt      = pa_r;
		pa_bits_nxt = pa_bits_r;
		unique case (pa_r)
			PA_IDLE: begin
				if (!run_n) begin
					pa_nxt = PA_WAIT_VCO;
				end
			end
			PA_WAIT_VCO: begin
				if (vco_rise) begin
					pa_nxt      = PA_HOLD;
					pa_bits_nxt = 2'h0;
				end
			end
			PA_HOLD: begin
				if (data_rise) begin
					pa_bits_nxt = 2'(pa_bits_r + 2'h1);
					if (pa_bits_r == 2'(ALIGN_BITS - 2'h1)) begin
						pa_nxt = PA_DONE;
					end
				end
			end
			PA_DONE: begin
				pa_nxt = PA_DONE;
			end
		endcase
		// Leaving the read returns the sequencer to rest
		if (!read_gate || run_n) begin
			pa_nxt      = PA_IDLE;
			pa_bits_nxt = 2'h0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pa_r      <= PA_IDLE;
			pa_bits_r <= 2'h0;
			align_n_r <= 1'b1;
		end else begin
			pa_r      <= pa_nxt;
			pa_bits_r <= pa_bits_nxt;
			align_n_r <= (pa_nxt != PA_HOLD);
		end
	end

	// Sample on phase detector. The window opens on each loop edge and
	// closes when the delayed copy arrives; that sets pump up, a VCO edge
	// inside an armed window sets pump down. Whichever comes first holds
	// its pump longer, so the net correction follows the phase error.
	assign both_set  = up_r && down_r;
	assign win_nxt   = loop_rise ? WIN_CYC :
		(win_r != 3'h0) ? 3'(win_r - 3'h1) : 3'h0;
	assign up_nxt    = both_set ? 1'b0 : (up_r || win_r == 3'h1);
	assign down_nxt  = both_set ? 1'b0 : (down_r || (vco_rise && armed_r));
	// Both pumps drop in the same cycle, so a balanced loop nets zero
	assign armed_nxt = loop_rise ? 1'b1 : (both_set ? 1'b0 : armed_r);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			armed_r <= 1'b0;
			win_r   <= 3'h0;
			up_r    <= 1'b0;
			down_r  <= 1'b0;
		end else begin
			armed_r <= armed_nxt;
			win_r   <= win_nxt;
			up_r    <= up_nxt;
			down_r  <= down_nxt;
		end
	end

	// Outputs, each straight from a flip-flop
	assign reference_clock_2x  = div_r[0];
	assign write_clock_1x      = div_r[1];
	assign recovered_clock     = rclk_r;
	assign loop_input          = loop_r;
	assign phase_align_pulse_n = align_n_r;
	assign pump_up             = up_r;
	assign pump_down           = down_r;
	assign run_detected_n      = run_n;
	assign reg_rdata           = rdata_r;

	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	property p_ref_toggle;
		osc_rise |=> (reference_clock_2x != $past(reference_clock_2x));
	endproperty
	a_ref_toggle: assert property (p_ref_toggle) else $error("reference did not toggle on crystal edge");

	property p_wclk_toggle;
		(osc_rise && div_r[0]) |=> (write_clock_1x != $past(write_clock_1x));
	endproperty
	a_wclk_toggle: assert property (p_wclk_toggle) else $error("write clock did not toggle at half rate");

	property p_loop_ref;
		run_detected_n |=> (loop_input == $past(reference_clock_2x));
	endproperty
	a_loop_ref: assert property (p_loop_ref) else $error("loop not fed from reference");

	property p_loop_data;
		!run_detected_n |=> (loop_input == $past(data_sync_r[1]));
	endproperty
	a_loop_data: assert property (p_loop_data) else $error("loop not fed from drive data");

	property p_gate_clears;
		!read_gate |=> (run_detected_n && run_count == 5'h00);
	endproperty
	a_gate_clears: assert property (p_gate_clears) else $error("gate low did not clear run logic");

	property p_rclk_div;
		vco_rise |=> (recovered_clock != $past(recovered_clock));
	endproperty
	a_rclk_div: assert property (p_rclk_div) else $error("recovered clock not VCO over two");

	property p_align_start;
		(pa_r == PA_WAIT_VCO && vco_rise && read_gate && !run_n) |=> !phase_align_pulse_n;
	endproperty
	a_align_start: assert property (p_align_start) else $error("align pulse missing after VCO edge");

	property p_align_end;
		(pa_r == PA_HOLD && data_rise && pa_bits_r == 2'h1) |=> phase_align_pulse_n;
	endproperty
	a_align_end: assert property (p_align_end) else $error("align pulse outlived second bit");

	property p_window;
		(loop_rise ##1 (!loop_rise && !both_set)[*2]) |=> pump_up;
	endproperty
	a_window: assert property (p_window) else $error("pump up not set when window closed");

	property p_both_reset;
		(pump_up && pump_down) |=> (!pump_up && !pump_down);
	endproperty
	a_both_reset: assert property (p_both_reset) else $error("detector not reset when both halves set");

	property p_down_on_vco;
		(vco_rise && armed_r && !both_set) |=> pump_down;
	endproperty
	a_down_on_vco: assert property (p_down_on_vco) else $error("VCO edge did not set pump down");

	property p_status_read;
		(reg_rd && reg_addr == REG_STAT) |=> (reg_rdata[STAT_RUN_BIT] == $past(run_detected_n));
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read lost run latch");

endmodule
`default_nettype wire

// ===== dv/mfmsep_drive_model.sv
`timescale 1ns/10ps
`default_nettype none
// Drive read stream: bursts of evenly spaced pulses, line idles low
module mfmsep_drive_model (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Burst request
	input  wire logic       start,
	input  wire logic [7:0] nbits,
	input  wire logic [4:0] gap,
	// Drive pin
	output logic            mfm_data,
	output logic            busy
);
	logic [7:0] left_r;
	logic [4:0] tick_r;

	// Two cycle pulses, one every gap cycles; gaps set the run spacing
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			left_r <= 8'h00;
			tick_r <= 5'h00;
			mfm_data <= 1'b0;
		end else if (start) begin
			left_r <= nbits;
			tick_r <= 5'h00;
		end else if (left_r != 8'h00) begin
			mfm_data <= (tick_r < 5'h02);
			if (tick_r == gap - 5'h01) begin
				tick_r <= 5'h00;
				left_r <= left_r - 8'h01;
			end else begin
				tick_r <= tick_r + 5'h01;
			end
		end else begin
			mfm_data <= 1'b0;
		end
	end

	assign busy = (left_r != 8'h00);
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import mfmsep_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic osc_4x_in = 1'b0;
	logic mfm_data_in;
	logic vco_in = 1'b0;
	logic ref2x, wclk, rclk, loop_in, pa_n, up, dn, run_n, busy;
	logic start = 1'b0;
	logic [7:0] nbits = 8'h00;
	logic [4:0] gap = 5'h0a;
	logic [1:0] osc_cnt = 2'h0;
	logic vco_en = 1'b0;
	logic p_osc, p_ref, p_wr, p_vco, p_rec, p_up, p_dn, p_run;
	logic [7:0] s;
	integer seed = 32'h8f367226;
	int errors = 0, checks = 0, osc_r = 0, ref_t = 0, wr_t = 0, vco_r = 0, rec_t = 0;
	int saw_pa = 0, saw_dn = 0, solo_up = 0, a0, a1, a2, k;

	mfmsep_top u_mfmsep_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.osc_4x_in(osc_4x_in), .mfm_data_in(mfm_data_in), .vco_in(vco_in),
		.reference_clock_2x(ref2x), .write_clock_1x(wclk), .recovered_clock(rclk),
		.loop_input(loop_in), .phase_align_pulse_n(pa_n), .pump_up(up), .pump_down(dn),
		.run_detected_n(run_n));
	mfmsep_drive_model u_mfmsep_drive_model (.clk_sys(clk_sys), .rst(rst), .start(start),
		.nbits(nbits), .gap(gap), .mfm_data(mfm_data_in), .busy(busy));

	// 50 MHz system clock
	always #10 clk_sys = ~clk_sys;

	// Crystal at a quarter of clk_sys; VCO pin random while enabled
	always @(posedge clk_sys) begin
		osc_cnt <= osc_cnt + 2'h1;
		osc_4x_in <= osc_cnt[1];
		if (vco_en)
			vco_in <= 1'($random(seed));
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Edge counters and cycle checks, sampled away from the launching edge
	always @(negedge clk_sys) begin
		osc_r += (osc_4x_in & ~p_osc);
		ref_t += (ref2x != p_ref);
		wr_t += (wclk != p_wr);
		vco_r += (vco_in & ~p_vco);
		rec_t += (rclk != p_rec);
		saw_pa += (pa_n === 1'b0);
		saw_dn += (dn === 1'b1);
		solo_up += (up === 1'b1 && dn === 1'b0);
		if (p_up & p_dn & ~rst)
			chk("pumps_clear", 8'h00, {6'h00, up, dn});
		// Loop register lags the reference by exactly one cycle
		if (run_n & p_run & ~rst & loop_in !== p_ref)
			chk("loop_ref", p_ref, loop_in);
		{p_osc, p_ref, p_wr, p_vco, p_rec, p_up, p_dn, p_run} =
			{osc_4x_in, ref2x, wclk, vco_in, rclk, up, dn, run_n};
	end

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask

	// One burst from the drive, bounded wait for it to finish
	task automatic burst(input logic [7:0] n, input logic [4:0] g);
		int i;
		@(posedge clk_sys);
		start <= 1'b1;
		nbits <= n;
		gap <= g;
		@(posedge clk_sys);
		start <= 1'b0;
		for (i = 0; i < 5000; i++) begin
			@(posedge clk_sys);
			if (!busy)
				break;
		end
		if (busy) begin
			errors++;
			$display("mismatch burst_done expected 0 seen 1");
			report_and_stop();
		end
		repeat (6) @(posedge clk_sys);
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		rd(REG_CTRL, s);
		chk("ctrl_reset", 8'h00, s);
		rd(REG_STAT, s);
		chk("stat_reset", 8'h03, s & 8'h03);
		rd(2'h3, s);
		chk("unmapped", 8'h00, s);
		$display("test reset done");
		// Windows of 200 cycles hold whole crystal periods; start on a
		// rising edge so the negedge counters cannot race the capture
		@(posedge clk_sys);
		a0 = osc_r; a1 = ref_t; a2 = wr_t;
		repeat (200) @(posedge clk_sys);
		chk("osc_rises", 8'd50, 8'(osc_r - a0));
		chk("ref_toggles", 8'd50, 8'(ref_t - a1));
		chk("wr_toggles", 8'd25, 8'(wr_t - a2));
		$display("test dividers done");
		burst(8'd20, 5'd10);
		chk("gate_off_run", 8'h01, {7'h00, run_n});
		wr(REG_CTRL, 8'hfd);
		rd(REG_CTRL, s);
		chk("ctrl_mask", 8'h01, s);
		burst(8'd15, 5'd12);
		repeat (30) @(posedge clk_sys);
		rd(REG_STAT, s);
		chk("short_run", 8'h01, s & 8'hf1);
		// One cycle past the class A timeout must break every run
		burst(8'd16, 5'd13);
		chk("slow_run_a", 8'h01, {7'h00, run_n});
		burst(8'd16, 5'd12);
		chk("run_a", 8'h00, {7'h00, run_n});
		rd(REG_STAT, s);
		chk("stat_run", 8'h00, s & 8'h01);
		$display("test run detect done");
		// No VCO edges: data always leads, so pump up stands alone
		a0 = solo_up;
		burst(8'd4, 5'd10);
		chk("data_leads", 8'h01, {7'h00, solo_up > a0});
		a1 = vco_r; a2 = rec_t;
		vco_en <= 1'b1;
		for (k = 0; k < 5; k++)
			burst(8'd8, 5'(6 + {$random(seed)} % 7));
		vco_en <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk("rclk_div", 8'(vco_r - a1), 8'(rec_t - a2));
		chk("align_seen", 8'h01, {7'h00, saw_pa > 0});
		chk("align_end", 8'h01, {7'h00, pa_n});
		chk("pump_dn_seen", 8'h01, {7'h00, saw_dn > 0});
		$display("test loop done");
		wr(REG_CTRL, 8'h00);
		repeat (3) @(posedge clk_sys);
		rd(REG_STAT, s);
		chk("gate_drop", 8'h01, s & 8'hf1);
		wr(REG_CTRL, 8'h03);
		burst(8'd16, 5'd14);
		chk("run_b", 8'h00, {7'h00, run_n});
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk("reset_outs", 8'h06, {5'h00, run_n, pa_n, up | dn});
		rd(REG_CTRL, s);
		chk("reset_ctrl", 8'h00, s);
		$display("test reset mid run done");
		report_and_stop();
	end
endmodule
`default_nettype wire
